// File: design/prp_ctrl_end.sv
// Purpose: controller end; APB registers drive pattern access commands
// Assumes: APB on MCLK; link clock made here by division
// Notes:   one command in flight; reads wait for the device strobe
`timescale 1ns/1ns
module prp_ctrl_end
  import prp_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  prp_link_if.ctrl         LINK
);

  // ----------------------------------------
  // link clock divider and data sync
  // ----------------------------------------
  logic [3:0]        div_cnt;
  logic              wrap;
  logic              rise_tick;
  logic              fall_tick;
  logic [8:0]        rdq_m;
  logic [8:0]        rdq_s;

  assign wrap      = div_cnt == 4'(CK_HALF_CYC - 1);
  assign rise_tick = wrap & ~LINK.ck;
  assign fall_tick = wrap & LINK.ck;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      div_cnt <= '0;
      LINK.ck <= 1'b0;
      rdq_m   <= '0;
      rdq_s   <= '0;
    end
    else if (CE)
    begin
      div_cnt <= wrap ? 4'h0 : div_cnt + 4'h1;
      LINK.ck <= LINK.ck ^ wrap;
      rdq_m   <= {LINK.rdq_valid, LINK.rdq};
      rdq_s   <= rdq_m;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic              done;
  logic              busy;
  logic              mode_on;
  logic              refused;
  logic              rvalid;
  logic [15:0]       rdata;

  assign done = PSEL & PENABLE & PREADY;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL && PENABLE && !PREADY)
      begin
        PSLVERR <= 1'b0;
        case (PADDR)
          REG_CMD:    PRDATA <= '0;
          REG_STATUS: PRDATA <= {28'h0, rvalid, refused, mode_on, busy};
          REG_RDATA:  PRDATA <= {16'h0, rdata};
          default:
          begin
            PRDATA  <= '0;
            PSLVERR <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // command acceptance
  // ----------------------------------------
  prp_cmd_t          new_code;
  logic              legal;
  logic              wr_cmd;
  logic              accept;
  logic              pend;
  prp_cmd_t          pend_code;
  logic [17:0]       pend_addr;
  logic [1:0]        pend_ba;
  logic [1:0]        pend_bg;
  logic              rd_wait;
  logic [3:0]        rfc_cnt;
  logic [2:0]        beat;

  assign new_code = prp_cmd_t'(PWDATA[CMD_CODE_LSB +: 4]);
  assign wr_cmd   = done & PWRITE & (PADDR == REG_CMD);
  assign busy     = pend | rd_wait | (rfc_cnt != 4'h0);
  assign accept   = wr_cmd & ~busy & legal;

  always_comb
  begin
    case (new_code)
      CMD_DES, CMD_MRS, CMD_RESET:
        legal = 1'b1;
      CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_REF:
        legal = mode_on;
      CMD_ACT, CMD_PRE, CMD_PDE, CMD_SRE:
        legal = ~mode_on;
      default:
        legal = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pend      <= 1'b0;
      pend_code <= CMD_DES;
      pend_addr <= '0;
      pend_ba   <= '0;
      pend_bg   <= '0;
    end
    else if (CE)
    begin
      if (accept)
      begin
        pend      <= 1'b1;
        pend_code <= new_code;
        pend_addr <= PWDATA[17:0];
        pend_ba   <= PWDATA[CMD_BA_LSB +: 2];
        pend_bg   <= PWDATA[CMD_BG_LSB +: 2];
        // pattern mode runs with fixed 1x refresh
        if (new_code == CMD_MRS && {PWDATA[CMD_BG_LSB], PWDATA[CMD_BA_LSB +: 2]} == MR_PATTERN)
          pend_addr[FGR_LSB +: 3] <= 3'h0;
      end
      else if (fall_tick)
        pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // link command drive
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      LINK.cmd   <= CMD_DES;
      LINK.addr  <= '0;
      LINK.ba    <= '0;
      LINK.bg    <= '0;
      LINK.act_n <= 1'b1;
      LINK.par   <= 1'b0;
      mode_on    <= 1'b0;
    end
    else if (CE && fall_tick)
    begin
      LINK.cmd   <= pend ? pend_code : CMD_DES;
      LINK.addr  <= pend ? pend_addr : 18'h0;
      LINK.ba    <= pend ? pend_ba : 2'h0;
      LINK.bg    <= pend ? pend_bg : 2'h0;
      LINK.act_n <= ~(pend & pend_code == CMD_ACT);
      LINK.par   <= pend & ^{pend_addr, pend_ba, pend_bg, ~(pend_code == CMD_ACT)};
      if (pend && pend_code == CMD_MRS && {pend_bg[0], pend_ba} == MR_PATTERN)
        mode_on <= pend_addr[PATTERN_BIT];
      else if (pend && pend_code == CMD_RESET)
        mode_on <= 1'b0;
    end
  end

  // ----------------------------------------
  // refresh wait and read capture
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
      rfc_cnt <= '0;
    else if (CE && fall_tick && pend && pend_code == CMD_REF)
      rfc_cnt <= 4'(RFC_CYC);
    else if (CE && rfc_cnt != 4'h0)
      rfc_cnt <= rfc_cnt - 4'h1;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rd_wait <= 1'b0;
      beat    <= '0;
      rdata   <= '0;
    end
    else if (CE && fall_tick && pend && (pend_code == CMD_RD || pend_code == CMD_RDA))
    begin
      rd_wait <= 1'b1;
      beat    <= 3'h0;
    end
    else if (CE && rise_tick && rd_wait && rdq_s[8])
    begin
      // data taken as sent, never inverted
      rdata[7:0] <= {rdata[6:0], rdq_s[0]};
      if (beat == 3'h0)
        rdata[15:8] <= rdq_s[7:0];
      beat <= beat + 3'h1;
      if (beat == LAST_UI)
        rd_wait <= 1'b0;
    end
  end

  // set wins over clear for both sticky bits
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      refused <= 1'b0;
      rvalid  <= 1'b0;
    end
    else if (CE)
    begin
      refused <= (wr_cmd & ~accept) |
                 (refused & ~(done & PWRITE & PADDR == REG_STATUS & PWDATA[ST_REFUSED]));
      rvalid  <= (rise_tick & rd_wait & rdq_s[8] & beat == LAST_UI) |
                 (rvalid & ~(done & ~PWRITE & PADDR == REG_RDATA));
    end
  end

endmodule : prp_ctrl_end

// File: design/prp_dram_end.sv
// Purpose: device end of the pattern register access mode
// Assumes: link signals change away from the rising link clock edge
// Notes:   link clock sampled by MCLK; one beat per link rising edge
//
// Operation
// - four pages of four 8-bit locations
// - page 0 any format, others serial
// - page 3 location 3 low nibble activate limit
// - no data inversion on pattern reads
// - mode register 3 bit 2 enables mode
// - controller issues only the allowed commands
// - read/write with precharge act as plain
// - no power-down or self refresh in mode
// - 1x refresh only, wait refresh cycle time
// - finish sequences before any refresh command
// - bits 12:11 select readout format
// - bits 1:0 select accessed page
// - location bit 7 is A7 and UI0
// - page 0 writable with fixed default patterns
// - refresh rate status field at bits 4:3
// - bank address selects the location read
// - page 0 writes kept until re-initialisation
// - data bursts after additive plus CAS latency
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module prp_dram_end
  import prp_pkg::*;
#(
  parameter logic [3:0] ACT_LIMIT   = 4'h0,
  parameter logic       HARD_REPAIR = 1'b0,
  parameter logic       SOFT_REPAIR = 1'b0
)
(
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire logic       CRC_ERROR,
  input  wire logic [2:0] CHIP_ID,
  prp_link_if.dram        LINK,
  output logic            MODE_ON,
  output logic            PARITY_ERROR
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_BURST = 3'b100
  } prp_dev_state_t;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [27:0]       link_m;
  logic [27:0]       link_s;
  logic              ck_m;
  logic              ck_s;
  logic              ck_d;
  logic              crc_m;
  logic              crc_s;
  logic [2:0]        id_m;
  logic [2:0]        id_s;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      link_m <= '0;
      link_s <= '0;
      ck_m   <= 1'b0;
      ck_s   <= 1'b0;
      ck_d   <= 1'b0;
      crc_m  <= 1'b0;
      crc_s  <= 1'b0;
      id_m   <= '0;
      id_s   <= '0;
    end
    else if (CE)
    begin
      link_m <= {LINK.cmd, LINK.addr, LINK.ba, LINK.bg, LINK.act_n, LINK.par};
      link_s <= link_m;
      ck_m   <= LINK.ck;
      ck_s   <= ck_m;
      ck_d   <= ck_s;
      crc_m  <= CRC_ERROR;
      crc_s  <= crc_m;
      id_m   <= CHIP_ID;
      id_s   <= id_m;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  prp_cmd_t          cmd_s;
  logic [17:0]       addr_s;
  logic [1:0]        ba_s;
  logic [1:0]        bg_s;
  logic              act_n_s;
  logic              par_s;
  logic              rise;
  logic              is_rd;
  logic              is_wr;
  logic              is_mrs;
  logic              is_reset;
  logic              par_bad;
  logic [2:0]        mr_idx;

  assign cmd_s    = prp_cmd_t'(link_s[27:24]);
  assign addr_s   = link_s[23:6];
  assign ba_s     = link_s[5:4];
  assign bg_s     = link_s[3:2];
  assign act_n_s  = link_s[1];
  assign par_s    = link_s[0];
  assign rise     = ck_s & ~ck_d;
  assign is_rd    = rise & MODE_ON & (cmd_s == CMD_RD || cmd_s == CMD_RDA);
  assign is_wr    = rise & MODE_ON & (cmd_s == CMD_WR || cmd_s == CMD_WRA);
  assign is_mrs   = rise & (cmd_s == CMD_MRS);
  assign is_reset = rise & (cmd_s == CMD_RESET);
  assign par_bad  = rise & (cmd_s != CMD_DES) &
                    (par_s != ^{addr_s, ba_s, bg_s, act_n_s});
  assign mr_idx   = {bg_s[0], ba_s};

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  logic [13:0]       mode_reg [0:7];
  logic [1:0]        page;
  logic [1:0]        fmt;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 8; i++)
        mode_reg[i] <= '0;
    end
    else if (CE && is_reset)
    begin
      for (int i = 0; i < 8; i++)
        mode_reg[i] <= '0;
    end
    else if (CE && is_mrs)
      mode_reg[mr_idx] <= addr_s[13:0];
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      MODE_ON <= 1'b0;
      page    <= 2'h0;
      fmt     <= FMT_SERIAL;
    end
    else if (CE && is_reset)
    begin
      MODE_ON <= 1'b0;
      page    <= 2'h0;
      fmt     <= FMT_SERIAL;
    end
    else if (CE && is_mrs && mr_idx == MR_PATTERN)
    begin
      MODE_ON <= addr_s[PATTERN_BIT];
      page    <= addr_s[PAGE_LSB +: 2];
      fmt     <= addr_s[FORMAT_LSB +: 2];
    end
  end

  // ----------------------------------------
  // page 0 pattern storage
  // ----------------------------------------
  logic [7:0]        page0 [0:3];

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 4; i++)
        page0[i] <= PAGE0_DEFAULT[i];
    end
    else if (CE && is_reset)
    begin
      for (int i = 0; i < 4; i++)
        page0[i] <= PAGE0_DEFAULT[i];
    end
    else if (CE && is_wr && page == 2'h0)
      page0[ba_s] <= addr_s[7:0];
  end

  // ----------------------------------------
  // error log
  // ----------------------------------------
  logic [17:0]       log_addr;
  logic [5:0]        log_ctl;
  logic [2:0]        log_cid;
  logic              crc_err;

  // only the first failing command is kept
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      log_addr <= '0;
      log_ctl  <= '0;
      log_cid  <= '0;
    end
    else if (CE && par_bad && !PARITY_ERROR)
    begin
      log_addr <= addr_s;
      log_ctl  <= {par_s, act_n_s, bg_s, ba_s};
      log_cid  <= id_s;
    end
  end

  // set wins over clear
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PARITY_ERROR <= 1'b0;
      crc_err      <= 1'b0;
    end
    else if (CE)
    begin
      PARITY_ERROR <= par_bad | (PARITY_ERROR & ~is_reset);
      crc_err      <= crc_s | (crc_err & ~is_reset);
    end
  end

  // ----------------------------------------
  // page contents
  // ----------------------------------------
  logic [3:0][7:0]   page_word;
  logic [1:0]        refstat;
  logic [1:0]        fmt_eff;

  always_comb
  begin
    case (mode_reg[MR_PATTERN][FGR_LSB +: 3])
      3'h0:    refstat = REFSTAT_1X;
      3'h1:    refstat = REFSTAT_2X;
      default: refstat = REFSTAT_SUB;
    endcase
  end

  always_comb
  begin
    case (page)
      2'h0:
      begin
        for (int i = 0; i < 4; i++)
          page_word[i] = page0[i];
      end
      2'h1:
      begin
        page_word[0] = log_addr[7:0];
        page_word[1] = log_addr[15:8];
        page_word[2] = {log_ctl, log_addr[17:16]};
        page_word[3] = {crc_err, PARITY_ERROR, mode_reg[5][2:0], log_cid};
      end
      2'h2:
      begin
        page_word[0] = {HARD_REPAIR, SOFT_REPAIR, 1'b0, refstat,
                        1'b0, mode_reg[2][10:9]};
        page_word[1] = {mode_reg[6][6], mode_reg[6][5:0], mode_reg[3][3]};
        page_word[2] = {mode_reg[0][6:4], mode_reg[0][2], mode_reg[0][12],
                        mode_reg[2][5:3]};
        page_word[3] = {mode_reg[1][10:8], mode_reg[5][8:6], mode_reg[2][2:1]};
      end
      default:
      begin
        page_word[0] = 8'h00;
        page_word[1] = 8'h00;
        page_word[2] = 8'h00;
        page_word[3] = {4'h0, ACT_LIMIT};
      end
    endcase
  end

  // pages 1 to 3 and the reserved code fall back to serial
  assign fmt_eff = (page != 2'h0 || fmt == 2'h3) ? FMT_SERIAL : fmt;

  // ----------------------------------------
  // read latency and burst
  // ----------------------------------------
  prp_dev_state_t    state;
  logic [6:0]        lat_cnt;
  logic [6:0]        cl;
  logic [6:0]        rl;
  logic [2:0]        ui;
  logic [2:0]        next_ui;
  logic [1:0]        rd_loc;
  logic [7:0]        lane_next;

  assign cl = CL_BASE + 7'({mode_reg[0][12], mode_reg[0][6:4], mode_reg[0][2]});
  assign rl = (mode_reg[1][4:3] == 2'h1) ? cl + cl - 7'h01 :
              (mode_reg[1][4:3] == 2'h2) ? cl + cl - 7'h02 : cl;
  assign next_ui = (state == ST_WAIT) ? 3'h0 : ui + 3'h1;

  prp_lane_map i_prp_lane_map (
    .words (page_word),
    .loc   (rd_loc),
    .fmt   (fmt_eff),
    .ui    (next_ui),
    .lanes (lane_next)
  );

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state          <= ST_IDLE;
      lat_cnt        <= '0;
      ui             <= '0;
      rd_loc         <= '0;
      LINK.rdq       <= '0;
      LINK.rdq_valid <= 1'b0;
    end
    else if (CE && is_reset)
    begin
      state          <= ST_IDLE;
      LINK.rdq       <= '0;
      LINK.rdq_valid <= 1'b0;
    end
    else if (CE && rise)
    begin
      case (state)
        ST_IDLE:
        begin
          if (is_rd)
          begin
            lat_cnt <= rl;
            rd_loc  <= ba_s;
            state   <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (lat_cnt == 7'h01)
          begin
            state          <= ST_BURST;
            ui             <= 3'h0;
            LINK.rdq       <= lane_next;
            LINK.rdq_valid <= 1'b1;
          end
          else
            lat_cnt <= lat_cnt - 7'h01;
        end
        ST_BURST:
        begin
          if (ui == LAST_UI)
          begin
            state          <= ST_IDLE;
            LINK.rdq       <= '0;
            LINK.rdq_valid <= 1'b0;
          end
          else
          begin
            ui       <= next_ui;
            LINK.rdq <= lane_next;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule : prp_dram_end

// File: design/prp_lane_map.sv
// Purpose: picks the lane bits of one burst beat
// Assumes: bit 7 of a location goes out first
// Notes:   purely combinational
`timescale 1ns/1ns
module prp_lane_map
  import prp_pkg::*;
(
  input  wire logic [3:0][7:0] words,
  input  wire logic [1:0]      loc,
  input  wire logic [1:0]      fmt,
  input  wire logic [2:0]      ui,
  output logic      [7:0]      lanes
);

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_lane
      logic [1:0] stag_loc;
      assign stag_loc = loc + 2'(g);
      // ~ui picks bit 7 at beat 0
      assign lanes[g] = (fmt == FMT_PARALLEL) ? words[loc][7 - g] :
                        (fmt == FMT_STAGGER)  ? words[stag_loc][~ui] :
                                                words[loc][~ui];
    end
  endgenerate

endmodule : prp_lane_map

// File: include/prp_link_if.sv
// Purpose: command and read data link between controller and device
// Assumes: ck made by the controller end
// Notes:   all signals one way; no wire resolution needed
`timescale 1ns/1ns
interface prp_link_if;
  logic                ck;
  prp_pkg::prp_cmd_t   cmd;
  logic [17:0]         addr;
  logic [1:0]          ba;
  logic [1:0]          bg;
  logic                act_n;
  logic                par;
  logic [7:0]          rdq;
  logic                rdq_valid;

  modport ctrl (output ck, cmd, addr, ba, bg, act_n, par, input rdq, rdq_valid);
  modport dram (input ck, cmd, addr, ba, bg, act_n, par, output rdq, rdq_valid);
endinterface : prp_link_if

// File: include/prp_pkg.sv
// Purpose: shared constants and types of the pattern register link
// Assumes: one command clock from the controller end
// Notes:   offsets are byte addresses of 32-bit words
package prp_pkg;

  // ----------------------------------------
  // link commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_DES   = 4'h0,
    CMD_MRS   = 4'h1,
    CMD_RD    = 4'h2,
    CMD_RDA   = 4'h3,
    CMD_WR    = 4'h4,
    CMD_WRA   = 4'h5,
    CMD_REF   = 4'h6,
    CMD_RESET = 4'h7,
    CMD_ACT   = 4'h8,
    CMD_PRE   = 4'h9,
    CMD_PDE   = 4'ha,
    CMD_SRE   = 4'hb
  } prp_cmd_t;

  // ----------------------------------------
  // mode register fields
  // ----------------------------------------
  localparam logic [2:0] MR_PATTERN   = 3'h3;
  localparam int         PATTERN_BIT  = 2;
  localparam int         FORMAT_LSB   = 11;
  localparam int         PAGE_LSB     = 0;
  localparam int         FGR_LSB      = 6;
  localparam logic [1:0] FMT_SERIAL   = 2'h0;
  localparam logic [1:0] FMT_PARALLEL = 2'h1;
  localparam logic [1:0] FMT_STAGGER  = 2'h2;
  localparam logic [1:0] REFSTAT_SUB  = 2'h0;
  localparam logic [1:0] REFSTAT_1X   = 2'h1;
  localparam logic [1:0] REFSTAT_2X   = 2'h2;
  localparam logic [6:0] CL_BASE      = 7'h09;
  localparam logic [2:0] LAST_UI      = 3'h7;
  localparam logic [7:0] PAGE0_DEFAULT [4] = '{8'h55, 8'h33, 8'h0f, 8'h00};

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_NS     = 100;
  localparam int LINK_CK_NS  = 800;
  localparam int CK_HALF_CYC = LINK_CK_NS / (2 * MCLK_NS);
  localparam int T_RFC_NS    = 350;
  localparam int RFC_CYC     = (T_RFC_NS + MCLK_NS - 1) / MCLK_NS;

  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_RDATA    = 8'h08;
  localparam int         CMD_BA_LSB   = 18;
  localparam int         CMD_BG_LSB   = 20;
  localparam int         CMD_CODE_LSB = 24;
  localparam int         ST_BUSY      = 0;
  localparam int         ST_MODE      = 1;
  localparam int         ST_REFUSED   = 2;
  localparam int         ST_RVALID    = 3;

endpackage : prp_pkg

// File: tb/prp_link_checker.sv
// Purpose: link protocol checker
// Assumes: both ends on one MCLK
// Notes:   mode tracked from MRS traffic
`timescale 1ns/1ns
module prp_link_checker
  import prp_pkg::*;
(
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic              ck,
  input wire prp_pkg::prp_cmd_t cmd,
  input wire logic [17:0]       addr,
  input wire logic [1:0]        ba,
  input wire logic [1:0]        bg,
  input wire logic              act_n,
  input wire logic              par,
  input wire logic [7:0]        rdq,
  input wire logic              rdq_valid
);
  logic       mode;
  logic [6:0] bl;
  logic [7:0] since_rd;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  always_ff @(posedge MCLK)
    if (RST || cmd == CMD_RESET) mode <= 1'b0;
    else if (cmd == CMD_MRS && {bg[0], ba} == MR_PATTERN) mode <= addr[PATTERN_BIT];
  always_ff @(posedge MCLK)
    if (RST || !rdq_valid) bl <= 7'h00;
    else bl <= bl + 7'h01;
  always_ff @(posedge MCLK)
    if (RST) since_rd <= 8'hff;
    else if (cmd inside {CMD_RD, CMD_RDA} && cmd != $past(cmd)) since_rd <= 8'h00;
    else if (since_rd != 8'hff) since_rd <= since_rd + 8'h01;
  property p_ck;
    $rose(ck) |-> ck[*4] ##1 (!ck)[*4] ##1 ck;
  endproperty
  a_ck: assert property (p_ck) else $error("link clock shape");
  property p_hold;
    (cmd != $past(cmd)) |=> $stable(cmd)[*7];
  endproperty
  a_hold: assert property (p_hold) else $error("command length");
  property p_par;
    par == ((cmd != CMD_DES) & (^{addr, ba, bg, act_n}));
  endproperty
  a_par: assert property (p_par) else $error("parity bad");
  property p_allowed;
    (mode && cmd != $past(cmd)) |->
      cmd inside {CMD_MRS, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_DES, CMD_REF, CMD_RESET};
  endproperty
  a_allowed: assert property (p_allowed) else $error("illegal command");
  property p_nopd;
    mode |-> !(cmd inside {CMD_PDE, CMD_SRE});
  endproperty
  a_nopd: assert property (p_nopd) else $error("power down in mode");
  property p_rfc;
    ($past(cmd) == CMD_REF && cmd != CMD_REF) |-> (cmd == CMD_DES)[*4];
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh gap");
  property p_burst;
    $fell(rdq_valid) |-> bl == 7'h40;
  endproperty
  a_burst: assert property (p_burst) else $error("burst length");
  property p_lat;
    $rose(rdq_valid) |-> since_rd >= 8'h46 && since_rd <= 8'h5a;
  endproperty
  a_lat: assert property (p_lat) else $error("read latency");
endmodule : prp_link_checker

// File: tb/test_dram_pattern_register_access.sv
// Purpose: apb driven test of both link ends
// Assumes: default mode registers, CL 9
// Notes:   apb results checked by a queue monitor
`timescale 1ns/1ns
module test_dram_pattern_register_access
  import prp_pkg::*;
;
  logic        MCLK = 1'b0, RST = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, v;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, mode_on, par_err;
  logic [2:0]  chip = 3'h0;
  logic        crc = 1'b0;
  logic [15:0] rnd = 16'h5d60;
  logic [65:0] sb[$], e;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  prp_link_if link();
  prp_ctrl_end i_prp_ctrl_end (.MCLK(MCLK), .RST(RST), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  prp_dram_end #(.ACT_LIMIT(4'ha), .HARD_REPAIR(1'b1), .SOFT_REPAIR(1'b0)) i_prp_dram_end (
    .MCLK(MCLK), .RST(RST), .CE(1'b1), .CRC_ERROR(crc), .CHIP_ID(chip), .LINK(link),
    .MODE_ON(mode_on), .PARITY_ERROR(par_err));
  prp_link_checker i_prp_link_checker (.MCLK(MCLK), .RST(RST), .ck(link.ck), .cmd(link.cmd),
    .addr(link.addr), .ba(link.ba), .bg(link.bg), .act_n(link.act_n), .par(link.par),
    .rdq(link.rdq), .rdq_valid(link.rdq_valid));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task check(input logic [32:0] s, input logic [32:0] x);
    checks_done++;
    if (s !== x)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h exp %h", $time, s, x);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] m,
           input logic [32:0] x);
    @(posedge MCLK);
    sb.push_back({m, x & m});
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0; chip <= rnd[2:0];
    rnd = lfsr(rnd);
    @(posedge MCLK);
    penable <= 1'b1;
    do @(posedge MCLK); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [3:0] c, input logic [1:0] ba, input logic [17:0] a);
    apb(1'b1, REG_CMD, {4'h0, c, 4'h0, ba, a}, 33'h100000000, 33'h0);
    do apb(1'b0, REG_STATUS, 32'h0, 33'h0, 33'h0); while (q[ST_BUSY] !== 1'b0);
    // let the device end take the command off the link
    repeat (8) @(posedge MCLK);
  endtask : cmd
  task status(input logic [31:0] x);
    apb(1'b0, REG_STATUS, 32'h0, 33'h100000007, {1'b0, x});
  endtask : status
  task rd(input logic [3:0] c, input logic [1:0] loc, input logic [15:0] m, input logic [7:0] d);
    cmd(c, loc, 18'h0);
    apb(1'b0, REG_RDATA, 32'h0, {17'h10000, m}, {17'h0, {8{d[7]}}, d});
  endtask : rd
  task mrs(input logic [1:0] fmt, input logic [1:0] page, input logic en);
    cmd(CMD_MRS, MR_PATTERN[1:0], {5'h0, fmt, 8'h0, en, page});
  endtask : mrs
  initial forever #50 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  always @(posedge MCLK)
    if (psel && penable && pready === 1'b1)
    begin
      e = sb.pop_front();
      check({pslverr, prdata} & e[65:33], e[32:0]);
    end
  initial
  begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    status(32'h0);
    apb(1'b0, 8'h0c, 32'h0, {33{1'b1}}, {1'b1, 32'h0});
    cmd(CMD_RD, 2'h0, 18'h0);
    status(32'h4);
    apb(1'b1, REG_STATUS, 32'h4, 33'h100000000, 33'h0);
    mrs(FMT_SERIAL, 2'h0, 1'b1);
    status(32'h2);
    check({32'h0, mode_on}, 33'h1);
    for (int i = 0; i < 4; i++) rd(CMD_RD, i[1:0], 16'hffff, PAGE0_DEFAULT[i]);
    v = rnd[7:0];
    cmd(CMD_WRA, 2'h2, {10'h0, v});
    rd(CMD_RDA, 2'h2, 16'hffff, v);
    cmd(CMD_WR, 2'h0, {10'h0, v});
    for (int i = 8; i < 12; i++)
    begin
      cmd(i[3:0], 2'h0, 18'h0);
      status(32'h6);
      apb(1'b1, REG_STATUS, 32'h4, 33'h100000000, 33'h0);
    end
    cmd(CMD_REF, 2'h0, 18'h0);
    status(32'h2);
    mrs(FMT_PARALLEL, 2'h0, 1'b1);
    rd(CMD_RD, 2'h0, 16'h00ff, {8{v[7]}});
    cmd(CMD_WR, 2'h1, 18'h000ff);
    mrs(FMT_STAGGER, 2'h0, 1'b1);
    cmd(CMD_RD, 2'h3, 18'h0);
    apb(1'b0, REG_RDATA, 32'h0, 33'h1000055ff, 33'h000004400);
    mrs(FMT_PARALLEL, 2'h3, 1'b1);
    rd(CMD_RD, 2'h3, 16'hffff, 8'h0a);
    cmd(CMD_WR, 2'h3, 18'h000ff);
    rd(CMD_RD, 2'h3, 16'hffff, 8'h0a);
    mrs(FMT_SERIAL, 2'h2, 1'b1);
    rd(CMD_RD, 2'h0, 16'hffff, 8'h88);
    crc <= 1'b1;
    mrs(FMT_SERIAL, 2'h1, 1'b1);
    rd(CMD_RD, 2'h3, 16'hffff, 8'h80);
    mrs(FMT_SERIAL, 2'h0, 1'b0);
    status(32'h0);
    check({32'h0, mode_on}, 33'h0);
    check({32'h0, par_err}, 33'h0);
    end_of_test();
  end
endmodule : test_dram_pattern_register_access
